/* File: design/sar_adc_pkg.sv */
// Purpose: shared constants for the successive-approximation converter control
// Assumes: 8-bit converter, 16-code channel field, AXI4-Lite register access
// Notes: printed register offsets are word indices; byte address is four times the index
package sar_adc_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [5:0] STATUS_CONTROL_INDEX = 6'h0E;
  localparam logic [5:0] RESULT_INDEX = 6'h0F;
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ***************************************************************
  // status and control field layout
  // ***************************************************************
  localparam int COCO_BIT = 7;
  localparam int RC_SELECT_BIT = 6;
  localparam int POWER_ON_BIT = 5;
  localparam int ZERO_BIT = 4;
  localparam int CHANNEL_LSB = 0;
  localparam int CHANNEL_W = 4;
  localparam int RESULT_W = 8;

  // ***************************************************************
  // channel codes
  // ***************************************************************
  localparam logic [3:0] CH_PC0 = 4'h0;
  localparam logic [3:0] CH_PC1 = 4'h1;
  localparam logic [3:0] CH_PC2 = 4'h2;
  localparam logic [3:0] CH_PC3 = 4'h3;
  localparam logic [3:0] CH_PB3 = 4'h4;
  localparam logic [3:0] CH_PB4 = 4'h5;
  localparam logic [3:0] CH_HIGH_REF = 4'hC;
  localparam logic [3:0] CH_LOW_REF = 4'hD;
  localparam logic [3:0] CH_QUARTER_REF = 4'hE;
  localparam logic [3:0] CH_HALF_REF = 4'hF;

  // ***************************************************************
  // conversion timing, in converter clock steps
  // ***************************************************************
  localparam int CONVERSION_PERIOD = 32;
  localparam logic [7:0] FIRST_TRIAL = 8'h80;

  // ***************************************************************
  // bus answers
  // ***************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sar_adc_pkg

/* File: design/seq_link_if.sv */
// Purpose: carries control and results between the register side and the sequencer
// Assumes: single clock domain
// Notes: restart and step are single-cycle qualifiers, done is a one-cycle pulse
interface seq_link_if;
  logic run;
  logic restart;
  logic step;
  logic cmp_above;
  logic [7:0] dac_code;
  logic sample_hold;
  logic done;
  logic [7:0] result;

  modport ctl (output run, output restart, output step, output cmp_above,
               input dac_code, input sample_hold, input done, input result);
  modport seq (input run, input restart, input step, input cmp_above,
               output dac_code, output sample_hold, output done, output result);
endinterface : seq_link_if

/* File: design/sar_sequencer.sv */
// Purpose: steps one successive-approximation conversion every conversion period
// Assumes: comparator answer is settled for the current dac code at each step
// Notes: free-running while run is high (powered and not in stop mode); a restart abandons the conversion under way
module sar_sequencer
  import sar_adc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  seq_link_if.seq link
);

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SAMPLE = 2'b01,
    SEQ_DECIDE = 2'b10,
    SEQ_WAIT = 2'b11
  } seq_state_type;

  typedef struct packed {
    seq_state_type state;
    logic [4:0] count;
    logic [7:0] approximation_register;
    logic done;
    logic [7:0] result;
  } seq_regs_type;

  localparam logic [4:0] LAST_COUNT = 5'(CONVERSION_PERIOD - 1);
  localparam logic [4:0] BIT_COUNT = 5'(RESULT_W);

  seq_regs_type seq_q;
  seq_regs_type seq_d;
  logic [2:0] bit_index;

  always_comb
  begin
    seq_d = seq_q;
    seq_d.done = 1'b0;
    bit_index = 3'(BIT_COUNT - seq_q.count);
    if (!link.run)
    begin
      seq_d.state = SEQ_IDLE;
      seq_d.count = 5'h00;
      seq_d.approximation_register = 8'h00;
    end
    else if (link.restart)
    begin
      seq_d.state = SEQ_SAMPLE;
      seq_d.count = 5'h00;
      seq_d.approximation_register = FIRST_TRIAL;
    end
    else if (link.step)
    begin
      unique case (seq_q.state)
        SEQ_IDLE:
        begin
          seq_d.state = SEQ_SAMPLE;
          seq_d.count = 5'h00;
          seq_d.approximation_register = FIRST_TRIAL;
        end
        // R20: sample then decide
        SEQ_SAMPLE:
        begin
          seq_d.state = SEQ_DECIDE;
          seq_d.count = 5'h01;
        end
        SEQ_DECIDE:
        begin
          // R02: keep bit when input at or above trial
          if (!link.cmp_above)
          begin
            seq_d.approximation_register[bit_index] = 1'b0;
          end
          if (bit_index != 3'h0)
          begin
            seq_d.approximation_register[bit_index - 3'h1] = 1'b1;
          end
          else
          begin
            seq_d.done = 1'b1;
            seq_d.result = seq_d.approximation_register;
            seq_d.state = SEQ_WAIT;
          end
          seq_d.count = seq_q.count + 5'h01;
        end
        SEQ_WAIT:
        begin
          // R08: next conversion after the period
          if (seq_q.count == LAST_COUNT)
          begin
            seq_d.state = SEQ_SAMPLE;
            seq_d.count = 5'h00;
            seq_d.approximation_register = FIRST_TRIAL;
          end
          else
          begin
            seq_d.count = seq_q.count + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seq_q <= '0;
    end
    else
    begin
      seq_q <= seq_d;
    end
  end

  assign link.dac_code = seq_q.approximation_register;
  assign link.sample_hold = (seq_q.state == SEQ_SAMPLE);
  assign link.done = seq_q.done;
  assign link.result = seq_q.result;

endmodule : sar_sequencer

/* File: design/sar_adc_control.sv */
// Purpose: register side, port-pin effects and power control of the 8-bit converter
// Assumes: AXI4-Lite master keeps one write and one read in flight at most
// Notes: the analog mux, capacitor dac and comparator sit outside this block
//
// Notes on behaviour
// R01: four-bit channel field; 0-5 inputs, 12-13 references, 14-15 internal points.
// R02: inputs at or above high reference give all ones, at low give zeros.
// R03: completion copies the approximation register into the result and sets the flag.
// R04: any status/control write aborts, clears the flag, restarts on new channel; the code acts only on writes with byte lane 0 enabled.
// R05: reset clears power-on and rc clock select, converter disabled.
// R06: flag clears on status/control write or on result register read.
// R07: clearing the flag starts a new conversion automatically.
// R08: while flag stays set, convert every 32 cycles, refresh result, flag stays.
// R09: rc clock select 1 runs converter from rc oscillator, 0 from system clock.
// R10: power-on 0 switches converter, charge pump and rc oscillator off.
// R11: software picks rc clock below 1MHz and waits about 1ms after switching.
// R12: powered converter makes the selected channel's port pin read as zero.
// R13: selected port-B pin loses its pull-up while power-on is set.
// R14: software never uses a pin as analog and digital input together.
// R15: converter keeps working in wait mode.
// R16: stop mode halts all conversion activity.
// R17: software clears power and rc bits in wait when unused, rc above 1MHz.
// R18: status layout: flag bit7 read-only, rc bit6, power bit5, zero bit4, channel 3:0.
// R19: result register is valid whenever the flag is set.
// R20: input sampled at conversion start, then one bit decision per step.
// R21: result holds until next completion and changes in a single cycle.
//
// Implementation choice: the AXI4-Lite slave port.
module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_above,
  input wire logic rc_tick,
  input wire logic stop_mode,
  output logic [7:0] dac_code,
  output logic sample_hold,
  output logic [3:0] mux_select,
  output logic converter_enable,
  output logic charge_pump_enable,
  output logic rc_osc_enable,
  output logic rc_clock_select,
  output logic [5:0] pc_read_zero,
  output logic [4:0] pb_read_zero,
  output logic [4:0] pb_pullup_off
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic coco;
    logic rc_select;
    logic power_on;
    logic [3:0] channel_select;
    logic [7:0] result;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } ctl_regs_type;

  ctl_regs_type ctl_q;
  ctl_regs_type ctl_d;

  seq_link_if link ();

  // ***************************************************************
  // decode helpers
  // ***************************************************************
  function automatic logic [1:0] map_address(input logic [ADDR_W-1:0] addr);
    logic [1:0] hit;
    hit = 2'h0;
    if (addr[1:0] == 2'h0 && (addr >> 2) == ADDR_W'(STATUS_CONTROL_INDEX))
    begin
      hit = 2'h1;
    end
    else if (addr[1:0] == 2'h0 && (addr >> 2) == ADDR_W'(RESULT_INDEX))
    begin
      hit = 2'h2;
    end
    return hit;
  endfunction : map_address

  // port C pins 0-5 carry inputs 0-3 and both references
  function automatic logic [5:0] port_c_pins(input logic [3:0] ch);
    logic [5:0] pins;
    pins = 6'h00;
    unique case (ch)
      CH_PC0: pins = 6'h01;
      CH_PC1: pins = 6'h02;
      CH_PC2: pins = 6'h04;
      CH_PC3: pins = 6'h08;
      CH_HIGH_REF: pins = 6'h10;
      CH_LOW_REF: pins = 6'h20;
      default: pins = 6'h00;
    endcase
    return pins;
  endfunction : port_c_pins

  // port B pins 3 and 4 carry inputs 4 and 5
  function automatic logic [4:0] port_b_pins(input logic [3:0] ch);
    logic [4:0] pins;
    pins = 5'h00;
    if (ch == CH_PB3)
    begin
      pins = 5'h08;
    end
    else if (ch == CH_PB4)
    begin
      pins = 5'h10;
    end
    return pins;
  endfunction : port_b_pins

  function automatic logic [7:0] status_byte(input ctl_regs_type r);
    logic [7:0] b;
    b = 8'h00;
    b[COCO_BIT] = r.coco;
    b[RC_SELECT_BIT] = r.rc_select;
    b[POWER_ON_BIT] = r.power_on;
    b[ZERO_BIT] = 1'b0;
    b[CHANNEL_LSB +: CHANNEL_W] = r.channel_select;
    return b;
  endfunction : status_byte

  // ***************************************************************
  // bus handshakes
  // ***************************************************************
  logic aw_take;
  logic w_take;
  logic aw_ready_now;
  logic w_ready_now;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic wr_fire;
  logic ar_take;
  logic status_write;
  logic result_read;
  logic coco_clear;

  assign aw_ready_now = !ctl_q.aw_held && !ctl_q.bvalid;
  assign w_ready_now = !ctl_q.w_held && !ctl_q.bvalid;
  assign aw_take = s_axi_awvalid && aw_ready_now;
  assign w_take = s_axi_wvalid && w_ready_now;
  assign wr_addr = ctl_q.aw_held ? ctl_q.aw_addr : s_axi_awaddr;
  assign wr_data = ctl_q.w_held ? ctl_q.w_data : s_axi_wdata[7:0];
  assign wr_lane0 = ctl_q.w_held ? ctl_q.w_lane0 : s_axi_wstrb[0];
  assign wr_fire = (ctl_q.aw_held || aw_take) && (ctl_q.w_held || w_take);
  assign ar_take = s_axi_arvalid && !ctl_q.rvalid;

  // R04: any write to status/control with byte lane 0 enabled
  assign status_write = wr_fire && wr_lane0 && (map_address(wr_addr) == 2'h1);
  assign result_read = ar_take && (map_address(s_axi_araddr) == 2'h2);

  // R06: flag clears on write or result read
  assign coco_clear = status_write || result_read;

  // ***************************************************************
  // register update
  // ***************************************************************
  always_comb
  begin
    ctl_d = ctl_q;
    // write channels, taken in either order
    if (aw_take && !wr_fire)
    begin
      ctl_d.aw_held = 1'b1;
      ctl_d.aw_addr = s_axi_awaddr;
    end
    if (w_take && !wr_fire)
    begin
      ctl_d.w_held = 1'b1;
      ctl_d.w_data = s_axi_wdata[7:0];
      ctl_d.w_lane0 = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      ctl_d.aw_held = 1'b0;
      ctl_d.w_held = 1'b0;
      ctl_d.bvalid = 1'b1;
      ctl_d.bresp = (map_address(wr_addr) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (ctl_q.bvalid && s_axi_bready)
    begin
      ctl_d.bvalid = 1'b0;
    end
    // R18: field layout, flag not writable
    if (status_write)
    begin
      ctl_d.rc_select = wr_data[RC_SELECT_BIT];
      ctl_d.power_on = wr_data[POWER_ON_BIT];
      ctl_d.channel_select = wr_data[CHANNEL_LSB +: CHANNEL_W];
    end
    // R03: copy result and set flag
    // R21: whole byte in one cycle
    if (link.done && !status_write)
    begin
      ctl_d.result = link.result;
      ctl_d.coco = 1'b1;
    end
    else if (coco_clear)
    begin
      ctl_d.coco = 1'b0;
    end
    // read channel
    if (ar_take)
    begin
      ctl_d.rvalid = 1'b1;
      unique case (map_address(s_axi_araddr))
        2'h1:
        begin
          ctl_d.rdata = status_byte(ctl_q);
          ctl_d.rresp = RESP_OKAY;
        end
        2'h2:
        begin
          ctl_d.rdata = ctl_q.result;
          ctl_d.rresp = RESP_OKAY;
        end
        default:
        begin
          ctl_d.rdata = 8'h00;
          ctl_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (ctl_q.rvalid && s_axi_rready)
    begin
      ctl_d.rvalid = 1'b0;
    end
  end

  // R05: reset clears power and rc select
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_q <= '0;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  // ***************************************************************
  // sequencer control
  // ***************************************************************
  // R10: converter runs only when powered
  // R16: stop mode halts conversions
  // R15: wait mode does not gate the converter
  assign link.run = ctl_q.power_on && !stop_mode;

  // R07: clearing the flag restarts conversion
  // a completion in the same cycle as a result read keeps the flag, so no restart then
  assign link.restart = status_write || (result_read && ctl_q.coco && !link.done);

  // R09: step on rc oscillator ticks or every clock
  // R11: rc ticks assumed stable before software selects them
  assign link.step = ctl_q.rc_select ? rc_tick : 1'b1;
  assign link.cmp_above = comparator_above;

  sar_sequencer u_sequencer (
    .sys_clk (sys_clk),
    .nrst (nrst),
    .link (link)
  );

  // ***************************************************************
  // analog side and port pins
  // ***************************************************************
  // R01: channel code drives the mux
  assign mux_select = ctl_q.channel_select;
  assign dac_code = link.dac_code;
  assign sample_hold = link.sample_hold;
  assign converter_enable = ctl_q.power_on;
  assign charge_pump_enable = ctl_q.power_on;
  assign rc_osc_enable = ctl_q.power_on && ctl_q.rc_select;
  assign rc_clock_select = ctl_q.rc_select;

  logic [5:0] pc_sel;
  logic [4:0] pb_sel;
  assign pc_sel = port_c_pins(ctl_q.channel_select);
  assign pb_sel = port_b_pins(ctl_q.channel_select);

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_port_c
      // R12: selected pin reads zero
      assign pc_read_zero[gi] = ctl_q.power_on && pc_sel[gi];
    end
    for (gi = 0; gi < 5; gi++)
    begin : g_port_b
      assign pb_read_zero[gi] = ctl_q.power_on && pb_sel[gi];
      // R13: pull-up off for selected pin
      assign pb_pullup_off[gi] = ctl_q.power_on && pb_sel[gi];
    end
  endgenerate

  // ***************************************************************
  // bus outputs
  // ***************************************************************
  assign s_axi_awready = aw_ready_now;
  assign s_axi_wready = w_ready_now;
  assign s_axi_bvalid = ctl_q.bvalid;
  assign s_axi_bresp = ctl_q.bresp;
  assign s_axi_arready = !ctl_q.rvalid;
  assign s_axi_rvalid = ctl_q.rvalid;
  assign s_axi_rresp = ctl_q.rresp;
  // R19: result readable whenever flag set
  assign s_axi_rdata = {24'h000000, ctl_q.rdata};

endmodule : sar_adc_control

/* File: verification/sar_adc_checker.sv */
// Purpose: port-level properties of the converter control block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the top module, watches its ports only
module sar_adc_checker
  import sar_adc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic stop_mode,
  input wire logic [7:0] dac_code,
  input wire logic sample_hold,
  input wire logic [3:0] mux_select,
  input wire logic converter_enable,
  input wire logic charge_pump_enable,
  input wire logic rc_osc_enable,
  input wire logic rc_clock_select,
  input wire logic [5:0] pc_read_zero,
  input wire logic [4:0] pb_read_zero,
  input wire logic [4:0] pb_pullup_off
);
  timeunit 1ns/1ps;
  logic wr_ctl;
  // a status write taken with lane 0 enabled
  assign wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_wstrb[0] && s_axi_awaddr == ADDR_W'({STATUS_CONTROL_INDEX, 2'b00});

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_channel;
    wr_ctl |=> mux_select == $past(s_axi_wdata[3:0]);
  endproperty
  a_channel: assert property (p_channel) else $error("channel not applied");
  property p_power;
    wr_ctl |=> converter_enable == $past(s_axi_wdata[POWER_ON_BIT])
      && charge_pump_enable == converter_enable;
  endproperty
  a_power: assert property (p_power) else $error("power bit not applied");
  property p_rc_select;
    wr_ctl |=> rc_clock_select == $past(s_axi_wdata[RC_SELECT_BIT]);
  endproperty
  a_rc_select: assert property (p_rc_select) else $error("clock select wrong");
  property p_rc_osc;
    rc_osc_enable == (converter_enable && rc_clock_select);
  endproperty
  a_rc_osc: assert property (p_rc_osc) else $error("rc oscillator enable wrong");
  property p_pins_off;
    !converter_enable |-> pc_read_zero == 6'h00 && pb_read_zero == 5'h00
      && pb_pullup_off == 5'h00;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pin effect while off");
  property p_ref_pin;
    converter_enable && mux_select == CH_HIGH_REF |-> pc_read_zero == 6'h10;
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference pin not zero");
  property p_pullup;
    converter_enable && mux_select == CH_PB4 |-> pb_pullup_off == 5'h10
      && pb_read_zero == 5'h10;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not removed");
  property p_stop;
    stop_mode [*3] |-> !sample_hold && dac_code == 8'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("activity in stop");
  property p_first_trial;
    $rose(sample_hold) |-> dac_code == FIRST_TRIAL;
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("bad first trial");
  property p_restart;
    wr_ctl && s_axi_wdata[POWER_ON_BIT] && !s_axi_wdata[RC_SELECT_BIT] && !stop_mode
      |-> ##[1:3] sample_hold;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on write");
  property p_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
endmodule : sar_adc_checker

bind sar_adc_control sar_adc_checker #(.ADDR_W(ADDR_W)) i_checker (
  .sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_rdata, .s_axi_rvalid, .stop_mode,
  .dac_code, .sample_hold, .mux_select, .converter_enable, .charge_pump_enable,
  .rc_osc_enable, .rc_clock_select, .pc_read_zero, .pb_read_zero, .pb_pullup_off
);

/* File: verification/analog_front_model.sv */
// Purpose: analog mux, sample capacitor and comparator facing the control block
// Assumes: one eight-bit level per channel code
// Notes: unused codes and a powered-off comparator give no stable answer
module analog_front_model
  import sar_adc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [3:0] mux_select,
  input wire logic sample_hold,
  input wire logic [7:0] dac_code,
  input wire logic converter_enable,
  input wire logic [127:0] levels,
  output logic comparator_above
);
  timeunit 1ns/1ps;
  logic [7:0] held_q;
  logic junk_q;
  logic unused_code;
  // codes 6 to 11 route nothing
  assign unused_code = mux_select > 4'h5 && mux_select < CH_HIGH_REF;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      held_q <= 8'h00;
      junk_q <= 1'b0;
    end
    else
    begin
      junk_q <= ~junk_q;
      // input held from the sample step
      if (sample_hold)
        held_q <= unused_code ? ~held_q : levels[mux_select*8 +: 8];
    end
  end
  // at or above the trial keeps the bit
  assign comparator_above = converter_enable ? (held_q >= dac_code) : junk_q;
endmodule : analog_front_model

/* File: verification/testbench.sv */
// Purpose: register-level test of the converter control block
// Assumes: channel levels come from the analog front model
// Notes: rc ticks come every other cycle while enabled
module testbench
  import sar_adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = {STATUS_CONTROL_INDEX, 2'b00};
  localparam logic [7:0] RES = {RESULT_INDEX, 2'b00};
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rc_tick = 1'b0, stop_mode = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic comparator_above, sample_hold, converter_enable, charge_pump_enable;
  logic rc_osc_enable, rc_clock_select;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0] dac_code;
  logic [3:0] mux_select;
  logic [5:0] pc_read_zero;
  logic [4:0] pb_read_zero, pb_pullup_off;
  logic [127:0] levels = 128'h0;
  logic rc_go = 1'b0;
  logic [3:0] chans [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [7:0] lvls [10] = '{8'h5A, 8'h01, 8'hFE, 8'h80, 8'h7F, 8'hC3, 8'hFF, 8'h00, 8'h40,
    8'h80};
  int n_errors = 0;
  int check_count = 0;

  sar_adc_control #(.ADDR_W(8)) i_dut (
    .sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .comparator_above, .rc_tick, .stop_mode, .dac_code,
    .sample_hold, .mux_select, .converter_enable, .charge_pump_enable, .rc_osc_enable,
    .rc_clock_select, .pc_read_zero, .pb_read_zero, .pb_pullup_off
  );
  analog_front_model i_model (
    .sys_clk, .nrst, .mux_select, .sample_hold, .dac_code, .converter_enable, .levels,
    .comparator_above
  );

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rc_tick <= rc_go & ~rc_tick;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic wa, ww;
    wa = 1'b1;
    ww = 1'b1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (wa || ww)
    begin
      @(posedge sys_clk);
      if (wa && s_axi_awready)
      begin
        wa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (ww && s_axi_wready)
      begin
        ww = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge sys_clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    axi_rd(a);
    check(rd, {24'h0, e});
  endtask : rd_chk

  // polls status a bounded number of times for the completion flag
  task wait_flag;
    rd = 32'h0;
    repeat (40) if (rd[7] !== 1'b1) axi_rd(CTL);
  endtask : wait_flag

  function automatic logic [15:0] pins(input logic [3:0] ch);
    logic [5:0] pc;
    logic [4:0] pb;
    pc = 6'h00;
    pb = 5'h00;
    case (ch)
      4'h0, 4'h1, 4'h2, 4'h3: pc = 6'h01 << ch;
      4'hC: pc = 6'h10;
      4'hD: pc = 6'h20;
      4'h4: pb = 5'h08;
      4'h5: pb = 5'h10;
      default: pc = 6'h00;
    endcase
    return {pb, pb, pc};
  endfunction : pins

  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // ****************************************************
  // tests
  // ****************************************************
  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(CTL, STATUS_CONTROL_RESET);
    check({converter_enable, rc_clock_select, rc_osc_enable}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk);
      levels[chans[i]*8 +: 8] <= lvls[i];
      axi_wr(CTL, {4'hB, chans[i]});
      check(rsp, RESP_OKAY);
      rd_chk(CTL, {4'h2, chans[i]});
      check({pb_pullup_off, pb_read_zero, pc_read_zero}, pins(chans[i]));
      wait_flag;
      check(rd[7], 1'b1);
      rd_chk(RES, lvls[i]);
      rd_chk(CTL, {4'h2, chans[i]});
    end
    $display("test channels done");
    @(posedge sys_clk);
    levels[127:120] <= 8'h3C;
    repeat (80) @(posedge sys_clk);
    rd_chk(CTL, 8'hAF);
    rd_chk(RES, 8'h3C);
    $display("test continuous done");
    wait_flag;
    stop_mode <= 1'b1;
    axi_wr(CTL, 8'h20);
    repeat (40) @(posedge sys_clk);
    rd_chk(CTL, 8'h20);
    stop_mode <= 1'b0;
    wait_flag;
    check(rd[7], 1'b1);
    rd_chk(RES, 8'h5A);
    $display("test stop done");
    rc_go <= 1'b1;
    axi_wr(CTL, 8'h61);
    check({rc_osc_enable, rc_clock_select, charge_pump_enable}, 32'h7);
    wait_flag;
    rd_chk(RES, 8'h01);
    rc_go <= 1'b0;
    axi_wr(CTL, 8'h61);
    repeat (40) @(posedge sys_clk);
    rd_chk(CTL, 8'h61);
    $display("test rc clock done");
    axi_wr(CTL, 8'h04);
    check({converter_enable, charge_pump_enable, rc_osc_enable, pb_pullup_off}, 32'h0);
    repeat (40) @(posedge sys_clk);
    rd_chk(CTL, 8'h04);
    axi_rd(8'h40);
    check(rsp, RESP_SLVERR);
    check(rd, 32'h0);
    axi_wr(8'h40, 8'h25);
    check(rsp, RESP_SLVERR);
    rd_chk(CTL, 8'h04);
    $display("test power and map done");
    close_out;
  end

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    close_out;
  end
endmodule : testbench
